/* pkg/tdsr_params.svh */
/*
  Constants of the tone-digit serial readout: timing figures, cycle
  counts, the digit code table and the state codes.
  Assumes a 10 MHz system clock.
*/
`ifndef TDSR_PARAMS_SVH
`define TDSR_PARAMS_SVH

// System clock rate
`define TDSR_CLK_HZ      10000000
// Energy decay interval in ms
`define TDSR_DECAY_MS    30
// Tone-present guard of delayed steering in ms
`define TDSR_GUARD_P_MS  40
// Tone-absent guard of delayed steering in ms
`define TDSR_GUARD_A_MS  40
// Cycle counts derived from the times
`define TDSR_DECAY_CYC   ((`TDSR_DECAY_MS * `TDSR_CLK_HZ) / 1000)
`define TDSR_GUARD_P_CYC ((`TDSR_GUARD_P_MS * `TDSR_CLK_HZ) / 1000)
`define TDSR_GUARD_A_CYC ((`TDSR_GUARD_A_MS * `TDSR_CLK_HZ) / 1000)
// Bits per digit and code table, nibble index is row*4+column
`define TDSR_BITS        4
`define TDSR_CODE_TABLE  64'h0cab_f987_e654_d321
// Readout phase codes
`define TDSR_PH_IDLE     3'h1
`define TDSR_PH_SHIFT    3'h2
`define TDSR_PH_SPENT    3'h4

`endif

/* pkg/tdsr_pkg.sv */
/*
  Types of the tone-digit serial readout.
  Assumes tdsr_params.svh is on the include path.
*/
`include "tdsr_params.svh"

package tdsr_pkg;

  // Readout phase, one-hot
  typedef enum logic [2:0] {
    PH_IDLE  = `TDSR_PH_IDLE,
    PH_SHIFT = `TDSR_PH_SHIFT,
    PH_SPENT = `TDSR_PH_SPENT
  } tdsr_phase_type;

endpackage : tdsr_pkg

/* design/tdsr_readout.sv */
/*
  Digital readout of a tone-digit receiver: steering, energy
  indication, serial digit shift-out on acknowledge pulses, powerdown.
  Assumes the detector supplies toneValid, toneRow, toneCol and
  levelAbove on sys_clk; shiftPulseIn and sleepRequestIn are pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tdsr_params.svh"

module tdsr_readout
  import tdsr_pkg::*;
#(
  parameter bit DELAYED_VARIANT = 1'b0,
  parameter int DECAY_CYC       = `TDSR_DECAY_CYC,
  parameter int GUARD_P_CYC     = `TDSR_GUARD_P_CYC,
  parameter int GUARD_A_CYC     = `TDSR_GUARD_A_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       toneValid,
  input  wire logic [1:0] toneRow,
  input  wire logic [1:0] toneCol,
  input  wire logic       levelAbove,
  input  wire logic       shiftPulseIn,
  input  wire logic       sleepRequestIn,
  output var  logic       earlySteeringOut,
  output var  logic       delayedSteeringOut,
  output var  logic       serialResultOut
);

  localparam int MAXC  = (DECAY_CYC > GUARD_P_CYC) ?
                         ((DECAY_CYC > GUARD_A_CYC) ? DECAY_CYC
                                                   : GUARD_A_CYC) :
                         ((GUARD_P_CYC > GUARD_A_CYC) ? GUARD_P_CYC
                                                     : GUARD_A_CYC);
  localparam int CNT_W = $clog2(MAXC + 1);
  localparam logic [63:0] CODES = `TDSR_CODE_TABLE;

  // Refuse counts the counters cannot serve
  if (DECAY_CYC < 1 || GUARD_P_CYC < 1 || GUARD_A_CYC < 1) begin : g_chk
    $error("tdsr_readout: cycle counts must be at least one");
  end

  typedef struct packed {
    logic                 ackS1;
    logic                 ackS2;
    logic                 ackPrev;
    logic                 slpS1;
    logic                 slpS2;
    logic                 slpPrev;
    logic                 powerDown;
    logic                 steerEarly;
    logic                 steerDelayed;
    logic [CNT_W-1:0]     guardCnt;
    logic                 energy;
    logic [CNT_W-1:0]     decayCnt;
    tdsr_phase_type       phase;
    logic [`TDSR_BITS-1:0] shiftBits;
    logic [2:0]           bitCnt;
    logic                 steerPrev;
    logic                 sdOut;
  } tdsr_state_type;

  tdsr_state_type stateReg;
  tdsr_state_type stateNext;

  logic                  ackRise;
  logic                  ackFall;
  logic                  slpRise;
  logic                  steerNow;
  logic                  steerRise;
  logic [`TDSR_BITS-1:0] digitCode;

  ////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised pins
  assign ackRise  = stateReg.ackS2 & ~stateReg.ackPrev;
  assign ackFall  = ~stateReg.ackS2 & stateReg.ackPrev;
  assign slpRise  = stateReg.slpS2 & ~stateReg.slpPrev;

  // Steering seen by the readout logic
  assign steerNow = DELAYED_VARIANT ? stateReg.steerDelayed
                                    : stateReg.steerEarly;
  assign steerRise = steerNow & ~stateReg.steerPrev;

  // Digit to code lookup
  assign digitCode = CODES[{toneRow, toneCol, 2'h0} +: `TDSR_BITS];

  ////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    stateNext = stateReg;

    // Two-flop synchronisers, reset low as the pulled-down pins
    stateNext.ackS1   = shiftPulseIn;
    stateNext.ackS2   = stateReg.ackS1;
    stateNext.ackPrev = stateReg.ackS2;
    stateNext.slpS1   = sleepRequestIn;
    stateNext.slpS2   = stateReg.slpS1;
    stateNext.slpPrev = stateReg.slpS2;
    stateNext.steerPrev = steerNow;

    // Powerdown entry on sleep rise with shift low, exit on sleep low
    if (slpRise && !stateReg.ackS2) begin
      stateNext.powerDown = 1'b1;
    end else if (!stateReg.slpS2) begin
      stateNext.powerDown = 1'b0;
    end

    // Early steering follows the detector
    stateNext.steerEarly = toneValid & ~stateNext.powerDown;

    // Delayed steering with present and absent guards
    if (stateNext.powerDown) begin
      stateNext.steerDelayed = 1'b0;
      stateNext.guardCnt     = '0;
    end else if (stateReg.steerEarly == stateReg.steerDelayed) begin
      stateNext.guardCnt = '0;
    end else if (stateReg.steerDelayed) begin
      if (stateReg.guardCnt == CNT_W'(GUARD_A_CYC - 1)) begin
        stateNext.steerDelayed = 1'b0;
        stateNext.guardCnt     = '0;
      end else begin
        stateNext.guardCnt = stateReg.guardCnt + 1'b1;
      end
    end else begin
      if (stateReg.guardCnt == CNT_W'(GUARD_P_CYC - 1)) begin
        stateNext.steerDelayed = 1'b1;
        stateNext.guardCnt     = '0;
      end else begin
        stateNext.guardCnt = stateReg.guardCnt + 1'b1;
      end
    end

    // Energy indication with integrator decay
    if (stateNext.powerDown) begin
      stateNext.energy   = 1'b0;
      stateNext.decayCnt = '0;
    end else if (levelAbove) begin
      stateNext.energy   = 1'b1;
      stateNext.decayCnt = CNT_W'(DECAY_CYC - 1);
    end else if (stateReg.decayCnt != '0) begin
      stateNext.decayCnt = stateReg.decayCnt - 1'b1;
    end else begin
      stateNext.energy = 1'b0;
    end

    // Readout sequencer
    case (stateReg.phase)
      PH_IDLE: begin
        if (ackRise && steerNow && !stateReg.powerDown) begin
          stateNext.shiftBits = digitCode;
          stateNext.bitCnt    = 3'h1;
          stateNext.phase     = PH_SHIFT;
        end
      end
      PH_SHIFT: begin
        // Stays here until all four pulses are given
        if (ackRise && stateReg.bitCnt < 3'h4) begin
          stateNext.shiftBits = stateReg.shiftBits >> 1;
          stateNext.bitCnt    = stateReg.bitCnt + 3'h1;
        end else if (ackFall && stateReg.bitCnt == 3'h4) begin
          stateNext.bitCnt = 3'h0;
          stateNext.phase  = PH_SPENT;
        end
      end
      PH_SPENT: begin
        if (steerRise) begin
          stateNext.phase = PH_IDLE;
        end
      end
      default: begin
        stateNext.phase  = PH_IDLE;
        stateNext.bitCnt = 3'h0;
      end
    endcase

    // Powerdown abandons any readout
    if (stateNext.powerDown) begin
      stateNext.phase  = PH_IDLE;
      stateNext.bitCnt = 3'h0;
    end

    // Result pin multiplexer
    if (stateNext.powerDown) begin
      stateNext.sdOut = 1'b0;
    end else if (stateNext.phase == PH_SHIFT) begin
      stateNext.sdOut = stateNext.shiftBits[0];
    end else begin
      stateNext.sdOut = stateNext.energy;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateReg <= '{phase: PH_IDLE, default: '0};
    end else begin
      stateReg <= stateNext;
    end
  end

  // Outputs straight from flip-flops
  assign earlySteeringOut   = DELAYED_VARIANT ? 1'b0
                                              : stateReg.steerEarly;
  assign delayedSteeringOut = DELAYED_VARIANT ? stateReg.steerDelayed
                                              : 1'b0;
  assign serialResultOut    = stateReg.sdOut;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  a_pd_outputs_low: assert property (
    stateReg.powerDown |-> !serialResultOut && !earlySteeringOut
                           && !delayedSteeringOut)
    else $error("outputs not low in powerdown");

  a_early_follow: assert property (
    toneValid && !stateNext.powerDown |=> stateReg.steerEarly)
    else $error("early steering missed tone");

  a_early_drop: assert property (
    !toneValid |=> !stateReg.steerEarly)
    else $error("early steering held without tone");

  a_delay_guard: assert property (
    stateReg.steerDelayed && !stateReg.steerEarly && !stateNext.powerDown
    && stateReg.guardCnt < CNT_W'(GUARD_A_CYC - 1)
    |=> stateReg.steerDelayed)
    else $error("delayed steering dropped before guard");

  a_energy_rise: assert property (
    levelAbove && !stateNext.powerDown |=> stateReg.energy)
    else $error("energy not raised");

  a_energy_hold: assert property (
    stateReg.energy && !levelAbove && stateReg.decayCnt != '0
    && !stateNext.powerDown |=> stateReg.energy)
    else $error("energy dropped before decay");

  a_energy_shown: assert property (
    stateReg.phase != PH_SHIFT && !stateReg.powerDown
    |-> serialResultOut == stateReg.energy)
    else $error("result pin not showing energy");

  a_first_lsb: assert property (
    stateReg.phase == PH_IDLE && ackRise && steerNow
    && !stateNext.powerDown |=> serialResultOut == $past(digitCode[0]))
    else $error("first bit not code LSB");

  a_next_bit: assert property (
    stateReg.phase == PH_SHIFT && ackRise && stateReg.bitCnt < 3'h4
    && !stateNext.powerDown
    |=> serialResultOut == $past(stateReg.shiftBits[1]))
    else $error("shift did not advance");

  a_extra_ignored: assert property (
    stateReg.phase == PH_SPENT && !steerRise && !stateNext.powerDown
    |=> stateReg.phase == PH_SPENT)
    else $error("readout rearmed without steering rise");

  a_end_restore: assert property (
    stateReg.phase == PH_SHIFT && ackFall && stateReg.bitCnt == 3'h4
    && !stateNext.powerDown
    |=> stateReg.phase == PH_SPENT && stateReg.bitCnt == 3'h0)
    else $error("readout end not handled");

endmodule : tdsr_readout
`default_nettype wire

/* verification/tdsr_host.sv */
/*
  Host model: clocks the digit out of the result pin with shift pulses.
  Assumes the readout block's result pin and a shared sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module tdsr_host (
  input  wire logic sys_clk,
  input  wire logic serialResultOut,
  output var  logic shiftPulseIn
);
  // Shift pin idles low, also while powerdown is requested
  initial shiftPulseIn = 1'b0;

  // Pulses 4 cycles high, 4 low (800 ns); bit read just after each fall
  task automatic pulse_read(input int first, input int n,
                            output logic [4:0] bits);
    bits = 5'h00;
    for (int i = first; i < first + n; i++) begin
      @(posedge sys_clk) shiftPulseIn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      shiftPulseIn <= 1'b0;
      @(negedge sys_clk);
      if (i < 5) bits[i] = serialResultOut;
      repeat (3) @(posedge sys_clk);
    end
  endtask : pulse_read

endmodule : tdsr_host

`default_nettype wire

/* verification/testbench.sv */
/*
  Self-checking bench of the tone-digit readout with a host model.
  Assumes short decay and guard parameters set below.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin checkCount++; \
  if ((got) !== (ex)) begin failCount++; \
  $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module testbench;
  logic       sys_clk, arst_n, toneValid, levelAbove, sleepRequestIn;
  logic [1:0] toneRow, toneCol;
  logic       shiftPulseIn, earlySteeringOut, delayedSteeringOut;
  logic       serialResultOut, delayedD, earlyD, resultD;
  logic [4:0] bitsA, bitsB;
  int         failCount, checkCount, cycleCount;

  // Early variant: its guard counters drive nothing visible
  tdsr_readout #(.DECAY_CYC(20))
    tdsr_readout_i (.sys_clk, .arst_n, .toneValid, .toneRow, .toneCol,
    .levelAbove, .shiftPulseIn, .sleepRequestIn, .earlySteeringOut,
    .delayedSteeringOut, .serialResultOut);
  // Delayed variant shares the inputs
  tdsr_readout #(.DELAYED_VARIANT(1'b1), .DECAY_CYC(20),
    .GUARD_P_CYC(30), .GUARD_A_CYC(30))
    tdsr_readout_d_i (.sys_clk, .arst_n, .toneValid, .toneRow, .toneCol,
    .levelAbove, .shiftPulseIn, .sleepRequestIn, .earlySteeringOut(earlyD),
    .delayedSteeringOut(delayedD), .serialResultOut(resultD));
  tdsr_host tdsr_host_i (.sys_clk, .serialResultOut, .shiftPulseIn);

  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycleCount++;
    if (cycleCount == 6000) begin
      failCount++;
      finish_test();
    end
  end

  // Code of a row and column worked out digit by digit
  function automatic logic [3:0] exp_code(int r, int c);
    if (c == 3) return (r == 3) ? 4'h0 : 4'(13 + r);
    if (r < 3) return 4'(r * 3 + c + 1);
    return (c == 0) ? 4'hb : (c == 1) ? 4'ha : 4'hc;
  endfunction : exp_code

  task automatic tone(input logic v, input int r, input int c);
    @(posedge sys_clk) toneValid <= v;
    toneRow <= 2'(r);
    toneCol <= 2'(c);
    repeat (3) @(posedge sys_clk);
  endtask : tone

  // Partial readout, new digit blocked, extra pulse ignored
  task automatic t_partial();
    tone(1'b1, 0, 0);
    tdsr_host_i.pulse_read(0, 2, bitsA);
    tone(1'b0, 0, 0);
    tone(1'b1, 2, 2);
    tdsr_host_i.pulse_read(2, 2, bitsB);
    `CHK("partial", 4'h1, {bitsB[3:2], bitsA[1:0]});
    repeat (8) @(posedge sys_clk);
    tdsr_host_i.pulse_read(4, 1, bitsA);
    `CHK("extra", 1'b0, bitsA[4]);
    tone(1'b0, 0, 0);
    $display("done partial");
  endtask : t_partial

  // All sixteen digits, energy shown again after readout
  task automatic t_codes();
    @(posedge sys_clk) levelAbove <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      tone(1'b1, k / 4, k % 4);
      `CHK("steer", 1'b1, earlySteeringOut);
      tdsr_host_i.pulse_read(0, 4, bitsA);
      `CHK("code", exp_code(k / 4, k % 4), bitsA[3:0]);
      repeat (6) @(posedge sys_clk);
      `CHK("energy", 1'b1, serialResultOut);
      tone(1'b0, 0, 0);
      `CHK("drop", 1'b0, earlySteeringOut);
    end
    $display("done codes");
  endtask : t_codes

  // Energy follows the level and decays after it goes
  task automatic t_energy();
    @(posedge sys_clk) levelAbove <= 1'b0;
    repeat (15) @(posedge sys_clk);
    `CHK("hold", 1'b1, serialResultOut);
    repeat (10) @(posedge sys_clk);
    `CHK("decay", 1'b0, serialResultOut);
    // On/off bursts of 60 cycles, the pin checked at the end of each
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk) levelAbove <= 1'b1;
      repeat (60) @(posedge sys_clk);
      `CHK("cad on", 1'b1, serialResultOut);
      levelAbove <= 1'b0;
      repeat (60) @(posedge sys_clk);
      `CHK("cad off", 1'b0, serialResultOut);
    end
    @(posedge sys_clk) levelAbove <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK("attack", 1'b1, serialResultOut);
    $display("done energy");
  endtask : t_energy

  // Powerdown forces outputs low, release restores the result pin
  task automatic t_sleep();
    tone(1'b1, 1, 1);
    @(posedge sys_clk) sleepRequestIn <= 1'b1;
    repeat (6) @(posedge sys_clk);
    `CHK("pd steer", 1'b0, earlySteeringOut);
    `CHK("pd result", 1'b0, serialResultOut);
    `CHK("pd result d", 1'b0, resultD);
    @(posedge sys_clk) sleepRequestIn <= 1'b0;
    repeat (6) @(posedge sys_clk);
    `CHK("wake", 1'b1, serialResultOut);
    tone(1'b0, 0, 0);
    $display("done sleep");
  endtask : t_sleep

  // Delayed steering guards on both edges
  task automatic t_delay();
    repeat (40) @(posedge sys_clk);
    tone(1'b1, 0, 1);
    repeat (17) @(posedge sys_clk);
    `CHK("dly early", 1'b0, delayedD);
    repeat (20) @(posedge sys_clk);
    `CHK("dly high", 1'b1, delayedD);
    `CHK("unused", 1'b0, delayedSteeringOut);
    `CHK("unused d", 1'b0, earlyD);
    tone(1'b0, 0, 0);
    repeat (17) @(posedge sys_clk);
    `CHK("dly hold", 1'b1, delayedD);
    repeat (20) @(posedge sys_clk);
    `CHK("dly low", 1'b0, delayedD);
    $display("done delay");
  endtask : t_delay

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // Reset, then the scenarios
  initial begin
    {arst_n, toneValid, levelAbove, sleepRequestIn} = 4'h0;
    {toneRow, toneCol} = 4'h0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_partial();
    t_codes();
    t_energy();
    t_sleep();
    t_delay();
    finish_test();
  end
endmodule : testbench

`default_nettype wire
